// *** six_vector_interrupt_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module six_vector_interrupt_control_tb;
  localparam logic [1:0] EN = svic_pkg::ADDR_ENABLE, ST = svic_pkg::ADDR_STATUS;
  localparam logic [1:0] MK = svic_pkg::ADDR_MASK, T2 = svic_pkg::ADDR_TMR2_CONTROL;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic e0 = 1'b1, e1 = 1'b1, trg = 1'b1, t0 = 1'b0, t1 = 1'b0, roll = 1'b0;
  logic ser = 1'b0, idle = 1'b0, slow = 1'b0;
  logic [1:0] a = 2'h0;
  logic [7:0] d = 8'h00, m;
  wire logic ack, valid, halt, irq;
  wire logic [7:0] rdata;
  wire logic [5:0] vec;
  logic [7:0] rq[$];
  logic [5:0] vq[$];
  int n_errors = 0, checked = 0, cyc = 0;
  // Clock
  initial forever #5 ref_clk_in = ~ref_clk_in;
  // Device and core model
  svic_core dut (.ref_clk_in, .rst_in, .reg_addr_in(a), .reg_wdata_in(d), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .ext_request_0_in(e0), .ext_request_1_in(e1),
    .tmr2_trigger_input_in(trg), .tmr0_ovf_in(t0), .tmr1_ovf_in(t1),
    .tmr2_high_byte_roll_in(roll), .serial_req_in(ser), .idle_req_in(idle),
    .vector_ack_in(ack), .vector_out(vec), .irq_valid_out(valid), .core_halt_out(halt),
    .irq_out(irq));
  svic_core_model core (.ref_clk_in, .rst_in, .irq_valid_in(valid), .slow_in(slow),
    .vector_ack_out(ack));
  task automatic chk(input logic [7:0] s, input logic [7:0] e, input string nm);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic bus(input logic w, input logic [1:0] ad, input logic [7:0] v);
    if (!w) rq.push_back(v);
    @(posedge ref_clk_in);
    a <= ad;
    d <= v;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic fire(input logic [5:0] s);
    @(posedge ref_clk_in);
    {roll, ser, t1, e1, t0, e0} <= {s[5], s[4], s[3], ~s[2], s[1], ~s[0]};
    @(posedge ref_clk_in);
    {roll, t1, t0} <= 3'h0;
  endtask : fire
  task automatic serve(input logic [5:0] s, input logic [5:0] v);
    vq.push_back(v);
    fire(s);
    repeat (60) if (!valid) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    {e1, e0, ser} <= 3'h6;
    repeat (80) if (vq.size() != 0) @(posedge ref_clk_in);
    #1;
    chk(8'(vq.size()), 8'h00, "pending");
  endtask : serve
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // Result monitor and watchdog
  always @(posedge ref_clk_in) begin
    cyc++;
    if (rd_d) chk(rdata, rq.pop_front(), "rdata");
    if (ack && valid) chk({2'h0, vec}, {2'h0, vq.pop_front()}, "vector");
    rd_d <= rd;
    if (cyc == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'h7CE19386));
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    m = 8'(($urandom() & 32'h3C) | 32'h1);
    bus(0, EN, svic_pkg::ENABLE_RST);
    bus(0, MK, svic_pkg::MASK_RST);
    bus(0, T2, svic_pkg::T2C_RST);
    bus(1, EN, 8'hBF);
    bus(0, EN, 8'hBF);
    bus(1, MK, m);
    bus(0, MK, m);
    $display("registers done");
    for (int i = 0; i < 6; i++) begin
      bus(1, EN, 8'h80 | (8'h01 << i));
      serve(6'h01 << i, 6'h01 << i);
      if (i == 5) begin
        bus(0, T2, 8'h80);
        bus(1, T2, 8'h00);
      end
      tick(2);
      chk({7'h0, irq}, {7'h0, m[i]}, "irq");
      bus(0, ST, 8'h01 << i);
      tick(3);
      chk({7'h0, irq}, 8'h00, "irq_clear");
    end
    $display("sources done");
    bus(1, EN, 8'h3F);
    fire(6'h02);
    tick(40);
    chk({7'h0, valid}, 8'h00, "gate_off");
    bus(1, EN, 8'h82);
    serve(6'h00, 6'h02);
    bus(1, EN, 8'h80);
    fire(6'h10);
    tick(40);
    chk({7'h0, valid}, 8'h00, "en_off");
    bus(1, EN, 8'h8A);
    vq.push_back(6'h02);
    slow <= 1'b1;
    serve(6'h0A, 6'h08);
    bus(0, ST, 8'h0A);
    slow <= 1'b0;
    $display("priority done");
    bus(1, EN, 8'hA0);
    bus(1, T2, 8'h08);
    trg <= 1'b0;
    serve(6'h00, 6'h20);
    bus(0, T2, 8'h48);
    trg <= 1'b1;
    bus(1, T2, 8'h00);
    bus(1, T2, 8'h18);
    trg <= 1'b0;
    serve(6'h20, 6'h20);
    bus(0, T2, 8'hD8);
    bus(1, T2, 8'h58);
    tick(40);
    chk({7'h0, valid}, 8'h00, "updown");
    bus(0, T2, 8'h58);
    bus(1, T2, 8'h20);
    fire(6'h20);
    tick(40);
    chk({7'h0, valid}, 8'h00, "baud");
    bus(0, T2, 8'h20);
    bus(1, EN, 8'h88);
    idle <= 1'b1;
    @(posedge ref_clk_in);
    idle <= 1'b0;
    tick(2);
    chk({7'h0, halt}, 8'h01, "halt");
    bus(0, EN, 8'h88);
    serve(6'h08, 6'h08);
    tick(2);
    chk({7'h0, halt}, 8'h00, "wake");
    $display("timer2 and idle done");
    report_and_stop();
  end
endmodule : six_vector_interrupt_control_tb
`default_nettype wire

// *** svic_core.sv ***
// Functional notes
// - Six vectors: two external, three timers, one serial port.
// - Each source has its own enable bit written by software.
// - Gate bit 7 clear blocks all acknowledges; set defers to per-source bits.
// - Bits: 5 timer2, 4 serial, 3 timer1, 2 ext1, 1 timer0, 0 ext0.
// - Enable bit one permits a source, zero blocks it.
// - Timer 2 request is OR of overflow and external flags.
// - Vectoring never clears timer 2 flags; software clears them.
// - Timer 0/1 flags set at S5P2, polled next machine cycle.
// - Timer 2 flag set at S2P2, polled same machine cycle.
// - Idle ends on any enabled interrupt or on hardware reset.
// - In idle the core halts while interrupt logic and registers keep state.
// - Outside up/down mode, with external enable set, falling trigger edge sets external flag.
// - In up/down mode the external flag raises no request.
// - In baud generator mode high byte rollover sets no overflow flag.
`timescale 1ns/1ps
`default_nettype none
module svic_core (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Event sources
  input wire logic ext_request_0_in,
  input wire logic ext_request_1_in,
  input wire logic tmr2_trigger_input_in,
  input wire logic tmr0_ovf_in,
  input wire logic tmr1_ovf_in,
  input wire logic tmr2_high_byte_roll_in,
  input wire logic serial_req_in,
  // Core handshake
  input wire logic idle_req_in,
  input wire logic vector_ack_in,
  output logic [5:0] vector_out,
  output logic irq_valid_out,
  output logic core_halt_out,
  output logic irq_out
);
  logic ext0_s;
  logic ext1_s;
  logic trig_s;
  logic trig_d_r;
  logic [7:0] interrupt_enable_r;
  logic [7:0] interrupt_enable_nxt;
  logic [7:0] tmr2_control_r;
  logic [7:0] tmr2_control_nxt;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [3:0] phase_r;
  logic [3:0] phase_nxt;
  logic tf0_r;
  logic tf0_nxt;
  logic tf1_r;
  logic tf1_nxt;
  logic tf0_pend_r;
  logic tf0_pend_nxt;
  logic tf1_pend_r;
  logic tf1_pend_nxt;
  logic tf2_pend_r;
  logic tf2_pend_nxt;
  logic [5:0] vector_r;
  logic [5:0] vector_nxt;
  logic valid_r;
  logic valid_nxt;
  logic irq_r;
  logic irq_nxt;
  svic_pkg::svic_state_type state_r;
  svic_pkg::svic_state_type state_nxt;
  svic_pkg::svic_src_type req;
  logic [5:0] req_vec;
  logic [5:0] en_vec;
  logic [5:0] pend;
  logic [5:0] pick;
  logic poll;
  logic trig_fall;
  logic [7:0] events;

  // Pin inputs cross into the clock domain
  svic_sync u_sync_ext0 (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in(ext_request_0_in),
    .level_out(ext0_s)
  );
  svic_sync u_sync_ext1 (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in(ext_request_1_in),
    .level_out(ext1_s)
  );
  svic_sync u_sync_trig (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in(tmr2_trigger_input_in),
    .level_out(trig_s)
  );

  // Machine-cycle phase counter and latched timer flags
  always_comb begin
    phase_nxt = (phase_r == svic_pkg::MC_LAST) ? 4'h0 : phase_r + 4'h1;
    tf0_pend_nxt = tf0_pend_r | tmr0_ovf_in;
    tf1_pend_nxt = tf1_pend_r | tmr1_ovf_in;
    tf0_nxt = tf0_r;
    tf1_nxt = tf1_r;
    // Vector taken clears timer 0/1 flags; timer 2 flags stay
    if (valid_r && vector_ack_in) begin
      if (vector_r[svic_pkg::EN_TMR0]) begin
        tf0_nxt = 1'b0;
      end
      if (vector_r[svic_pkg::EN_TMR1]) begin
        tf1_nxt = 1'b0;
      end
    end
    // Set at S5P2 wins over a clear in the same cycle
    if (phase_r == svic_pkg::PH_S5P2) begin
      tf0_nxt = tf0_nxt | tf0_pend_nxt;
      tf1_nxt = tf1_nxt | tf1_pend_nxt;
      tf0_pend_nxt = 1'b0;
      tf1_pend_nxt = 1'b0;
    end
  end

  // Timer 2 control: hardware set beats software clear
  always_comb begin
    trig_fall = trig_d_r & ~trig_s;
    tmr2_control_nxt = tmr2_control_r;
    if (reg_wr_in && reg_addr_in == svic_pkg::ADDR_TMR2_CONTROL) begin
      tmr2_control_nxt = reg_wdata_in;
    end
    // Rollover waits for S2P2 to set the flag; none while baud generator
    tf2_pend_nxt = tf2_pend_r;
    if (tmr2_high_byte_roll_in && !tmr2_control_r[svic_pkg::T2C_BAUD]) begin
      tf2_pend_nxt = 1'b1;
    end
    if (phase_r == svic_pkg::PH_S2P2) begin
      if (tf2_pend_nxt) begin
        tmr2_control_nxt[svic_pkg::T2C_OVF] = 1'b1;
      end
      tf2_pend_nxt = 1'b0;
    end
    if (tmr2_control_r[svic_pkg::T2C_UPDOWN]) begin
      if (tmr2_high_byte_roll_in) begin
        tmr2_control_nxt[svic_pkg::T2C_EXT] = ~tmr2_control_r[svic_pkg::T2C_EXT];
      end
    end else if (trig_fall && tmr2_control_r[svic_pkg::T2C_EXTEN]) begin
      tmr2_control_nxt[svic_pkg::T2C_EXT] = 1'b1;
    end
  end

  // Request vector, enables, priority pick
  always_comb begin
    req.ext_request_0 = ~ext0_s;
    req.ext_request_1 = ~ext1_s;
    req.tmr0_overflow = tf0_r;
    req.tmr1_overflow = tf1_r;
    req.tmr2_overflow = tmr2_control_r[svic_pkg::T2C_OVF]
      | (tmr2_control_r[svic_pkg::T2C_EXT] & ~tmr2_control_r[svic_pkg::T2C_UPDOWN]);
    req.serial_req = serial_req_in;
    // Order matches enable bit positions
    req_vec = {req.tmr2_overflow, req.serial_req, req.tmr1_overflow,
               req.ext_request_1, req.tmr0_overflow, req.ext_request_0};
    en_vec = interrupt_enable_r[5:0];
    pend = interrupt_enable_r[svic_pkg::GATE_BIT] ? (req_vec & en_vec) : 6'h00;
    pick = pend & (~pend + 6'h01);
    // Poll at S5P2: sees a timer 2 flag of this cycle, timer 0/1 flags of the last
    poll = (phase_r == svic_pkg::PH_S5P2);
  end

  // Vector handshake to the core
  always_comb begin
    vector_nxt = vector_r;
    valid_nxt = valid_r;
    if (valid_r && vector_ack_in) begin
      valid_nxt = 1'b0;
      vector_nxt = svic_pkg::NO_VECTOR;
    end else if (!valid_r && poll && pend != 6'h00) begin
      valid_nxt = 1'b1;
      vector_nxt = pick;
    end
  end

  // Run and idle state of the core
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      svic_pkg::ST_RUN: begin
        if (idle_req_in) begin
          state_nxt = svic_pkg::ST_IDLE;
        end
      end
      svic_pkg::ST_IDLE: begin
        if (pend != 6'h00) begin
          state_nxt = svic_pkg::ST_RUN;
        end
      end
    endcase
  end

  // Software registers, sticky status, read path
  always_comb begin
    events = {2'b00, pick & {6{poll && !valid_r}}};
    interrupt_enable_nxt = interrupt_enable_r;
    mask_nxt = mask_r;
    status_nxt = status_r;
    rdata_nxt = 8'h00;
    if (reg_wr_in && reg_addr_in == svic_pkg::ADDR_ENABLE) begin
      interrupt_enable_nxt = reg_wdata_in & ~(8'h01 << svic_pkg::RSVD_BIT);
    end
    if (reg_wr_in && reg_addr_in == svic_pkg::ADDR_MASK) begin
      mask_nxt = reg_wdata_in;
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        svic_pkg::ADDR_ENABLE: rdata_nxt = interrupt_enable_r;
        svic_pkg::ADDR_STATUS: begin
          rdata_nxt = status_r;
          status_nxt = 8'h00;
        end
        svic_pkg::ADDR_MASK: rdata_nxt = mask_r;
        svic_pkg::ADDR_TMR2_CONTROL: rdata_nxt = tmr2_control_r;
      endcase
    end
    status_nxt = status_nxt | events;
    irq_nxt = (status_nxt & mask_nxt) != 8'h00;
  end

  // All state registers
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_d_r <= 1'b1;
      interrupt_enable_r <= svic_pkg::ENABLE_RST;
      tmr2_control_r <= svic_pkg::T2C_RST;
      status_r <= 8'h00;
      mask_r <= svic_pkg::MASK_RST;
      rdata_r <= 8'h00;
      phase_r <= 4'h0;
      tf0_r <= 1'b0;
      tf1_r <= 1'b0;
      tf0_pend_r <= 1'b0;
      tf1_pend_r <= 1'b0;
      tf2_pend_r <= 1'b0;
      vector_r <= svic_pkg::NO_VECTOR;
      valid_r <= 1'b0;
      irq_r <= 1'b0;
      state_r <= svic_pkg::ST_RUN;
    end else begin
      trig_d_r <= trig_s;
      interrupt_enable_r <= interrupt_enable_nxt;
      tmr2_control_r <= tmr2_control_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      phase_r <= phase_nxt;
      tf0_r <= tf0_nxt;
      tf1_r <= tf1_nxt;
      tf0_pend_r <= tf0_pend_nxt;
      tf1_pend_r <= tf1_pend_nxt;
      tf2_pend_r <= tf2_pend_nxt;
      vector_r <= vector_nxt;
      valid_r <= valid_nxt;
      irq_r <= irq_nxt;
      state_r <= state_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign vector_out = vector_r;
  assign irq_valid_out = valid_r;
  assign core_halt_out = state_r[1]; // Idle bit of the one-hot state flop
  assign irq_out = irq_r;
endmodule : svic_core
`default_nettype wire

// *** svic_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Core model: takes each offered vector at once or after five cycles
module svic_core_model (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Vector handshake
  input wire logic irq_valid_in,
  input wire logic slow_in,
  output logic vector_ack_out
);
  logic [2:0] wait_r;
  // One ack pulse per vector, then a cycle for the valid to drop
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_r <= 3'h0;
      vector_ack_out <= 1'b0;
    end else if (vector_ack_out) begin
      wait_r <= 3'h0;
      vector_ack_out <= 1'b0;
    end else if (irq_valid_in) begin
      wait_r <= wait_r + 3'h1;
      vector_ack_out <= (wait_r >= (slow_in ? 3'h5 : 3'h0));
    end
  end
endmodule : svic_core_model
`default_nettype wire

// *** svic_core_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the interrupt controller
module svic_core_sva (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Core handshake
  input wire logic idle_req_in,
  input wire logic vector_ack_in,
  input wire logic [5:0] vector_out,
  input wire logic irq_valid_out,
  input wire logic core_halt_out
);
  logic [7:0] en_r;
  logic rd_en;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  assign rd_en = reg_rd_in && reg_addr_in == svic_pkg::ADDR_ENABLE;
  // Shadow of the enable register
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) en_r <= svic_pkg::ENABLE_RST;
    else if (reg_wr_in && reg_addr_in == svic_pkg::ADDR_ENABLE) en_r <= reg_wdata_in;
  end
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside its slot");
  en_readback_a: assert property ($past(rd_en) |-> reg_rdata_out == ($past(en_r) & 8'hBF))
    else $error("enable readback wrong");
  gate_closed_a: assert property ($rose(irq_valid_out) |-> en_r[7])
    else $error("vector with gate closed");
  en_block_a: assert property ($rose(irq_valid_out) |-> (vector_out & ~en_r[5:0]) == 6'h00)
    else $error("vector of disabled source");
  vec_onehot_a: assert property (irq_valid_out |-> $onehot(vector_out))
    else $error("vector not one-hot");
  valid_hold_a: assert property (irq_valid_out && !vector_ack_in |=> irq_valid_out && $stable(vector_out))
    else $error("vector changed before ack");
  halt_cause_a: assert property ($rose(core_halt_out) |-> $past(idle_req_in))
    else $error("halt without idle request");
  idle_wake_a: assert property ($fell(core_halt_out) |-> ##[0:12] irq_valid_out)
    else $error("wake without interrupt");
  cover property ($rose(irq_valid_out));
  cover property (irq_valid_out && vector_ack_in);
  cover property ($rose(core_halt_out));
endmodule : svic_core_sva
bind svic_core svic_core_sva chk_i (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .idle_req_in(idle_req_in),
  .vector_ack_in(vector_ack_in),
  .vector_out(vector_out),
  .irq_valid_out(irq_valid_out),
  .core_halt_out(core_halt_out)
);
`default_nettype wire

// *** svic_pkg.sv ***
`default_nettype none
package svic_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] ADDR_ENABLE = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MASK = 2'h2;
  localparam logic [1:0] ADDR_TMR2_CONTROL = 2'h3;
  // Enable register layout
  localparam int GATE_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int EN_TMR2 = 5;
  localparam int EN_SERIAL = 4;
  localparam int EN_TMR1 = 3;
  localparam int EN_EXT1 = 2;
  localparam int EN_TMR0 = 1;
  localparam int EN_EXT0 = 0;
  // Timer 2 control layout
  localparam int T2C_OVF = 7;
  localparam int T2C_EXT = 6;
  localparam int T2C_BAUD = 5;
  localparam int T2C_UPDOWN = 4;
  localparam int T2C_EXTEN = 3;
  // Reset values
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] T2C_RST = 8'h00;
  localparam logic [5:0] NO_VECTOR = 6'h00;
  // Machine cycle: 12 clocks, state S1..S6 with two phases each
  localparam int unsigned MC_LEN = 12;
  localparam logic [3:0] MC_LAST = 4'hB;
  localparam logic [3:0] PH_S2P2 = 4'h3;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam int unsigned NUM_SRC = 6;

  typedef struct packed {
    logic serial_req;
    logic tmr2_overflow;
    logic tmr1_overflow;
    logic tmr0_overflow;
    logic ext_request_1;
    logic ext_request_0;
  } svic_src_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_IDLE = 2'b10
  } svic_state_type;
endpackage : svic_pkg
`default_nettype wire

// *** svic_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module svic_sync (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Asynchronous level and filtered result
  input wire logic async_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic level_nxt;

  // Hold last agreed value while stages disagree
  always_comb begin
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
  end

  // Sync chain, idle high as the pins are
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_r <= 1'b1;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;
endmodule : svic_sync
`default_nettype wire
